// >>> src/owd_pkg.sv
// shared constants for the one-wire dimming control block
package owd_pkg;
    // system clock rate in MHz (40 ns period)
    localparam int unsigned CLK_MHZ = 25;
    // timing figures in microseconds
    localparam int unsigned DET_DELAY_US = 100;
    localparam int unsigned DET_LOW_US = 260;
    localparam int unsigned DET_WIN_US = 1000;
    localparam int unsigned SOFT_START_US = 6000;
    localparam int unsigned EN_OFF_US = 5000;
    localparam int unsigned PWM_OFF_US = 40000;
    localparam int unsigned ACK_HOLD_US = 512;
    localparam int unsigned PHASE_MAX_US = 360;
    // cycle counts derived from the figures
    localparam int unsigned DET_DELAY_CYC = DET_DELAY_US * CLK_MHZ;
    localparam int unsigned DET_LOW_CYC = DET_LOW_US * CLK_MHZ;
    localparam int unsigned DET_WIN_CYC = DET_WIN_US * CLK_MHZ;
    localparam int unsigned SOFT_START_CYC = SOFT_START_US * CLK_MHZ;
    localparam int unsigned EN_OFF_CYC = EN_OFF_US * CLK_MHZ;
    localparam int unsigned PWM_OFF_CYC = PWM_OFF_US * CLK_MHZ;
    localparam int unsigned ACK_HOLD_CYC = ACK_HOLD_US * CLK_MHZ;
    localparam int unsigned PHASE_MAX_CYC = PHASE_MAX_US * CLK_MHZ;
    // widths
    localparam int CNT_W = 20;
    localparam int CODE_W = 9;
    localparam int FRAME_W = 24;
    localparam int ADDR_W = 8;
    localparam int BITCNT_W = 5;
    // command field positions
    localparam int ADDR_LSB = 16;
    localparam int ACK_REQ_BIT = 10;
    localparam int CODE_MSB = 8;
    localparam logic [BITCNT_W-1:0] LAST_BIT_IDX = 5'h17;
    // brightness code reset value and full-scale step count
    localparam logic [CODE_W-1:0] CODE_RESET = 9'h1FF;
    localparam logic [CODE_W-1:0] CODE_FULL_STEPS = 9'h1FF;
    // main sequence states, one-hot
    typedef enum logic [4:0] {
        ST_OFF  = 5'h01,
        ST_DET  = 5'h02,
        ST_CHD  = 5'h04,
        ST_SOFT = 5'h08,
        ST_RUN  = 5'h10
    } owd_state_t;
endpackage

// >>> src/owd_top.sv
// start-up sequencing, mode detection and one-wire receiver
`timescale 1ns/100ps
module owd_top
    import owd_pkg::*;
#(
    // device address, value arbitrary
    parameter logic [ADDR_W-1:0] DEV_ADDR = 8'hA5,
    parameter int unsigned DET_LOW = DET_LOW_CYC,
    parameter int unsigned DET_WIN = DET_WIN_CYC,
    parameter int unsigned SOFT_START = SOFT_START_CYC,
    parameter int unsigned EN_OFF = EN_OFF_CYC,
    parameter int unsigned PWM_OFF = PWM_OFF_CYC,
    parameter int unsigned ACK_HOLD = ACK_HOLD_CYC,
    parameter int unsigned PHASE_MAX = PHASE_MAX_CYC
) (
    input wire logic CLK_SYS_IN,
    input wire logic RESETN_IN,
    input wire logic EN_IN,
    input wire logic PWM_IN,
    input wire logic UVLO_OK_IN,
    input wire logic CHAN_DET_DONE_IN,
    output logic EN_OUT,
    output logic EN_OE_OUT,
    output logic DEVICE_ON_OUT,
    output logic DIGITAL_MODE_OUT,
    output logic BOOST_RUN_OUT,
    output logic ILIM_NORMAL_OUT,
    output logic [CODE_W-1:0] BRIGHT_CODE_OUT,
    output logic CMD_ACCEPT_OUT
);
    localparam logic [CNT_W-1:0] K_DLY = CNT_W'(DET_DELAY_CYC);
    localparam logic [CNT_W-1:0] K_DET = CNT_W'(DET_LOW);
    localparam logic [CNT_W-1:0] K_WIN = CNT_W'(DET_WIN - 1);
    localparam logic [CNT_W-1:0] K_SOFT = CNT_W'(SOFT_START - 1);
    localparam logic [CNT_W-1:0] K_EN_OFF = CNT_W'(EN_OFF);
    localparam logic [CNT_W-1:0] K_PWM_OFF = CNT_W'(PWM_OFF);
    localparam logic [CNT_W-1:0] K_ACK = CNT_W'(ACK_HOLD - 1);
    localparam logic [CNT_W-1:0] K_PH_MAX = CNT_W'(PHASE_MAX);

    function automatic logic [CNT_W-1:0] sat_inc(
        input logic [CNT_W-1:0] c
    );
        return (&c) ? c : c + 1'b1;
    endfunction

    // pin synchronisers: three flops, change taken when stages 2 and 3 agree
    logic [2:0] pin_raw;
    wire [2:0] pin_q;
    assign pin_raw = {UVLO_OK_IN, PWM_IN, EN_IN};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            logic s1_q, s2_q, s3_q, lvl_q;
            always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
                if (!RESETN_IN) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    lvl_q <= 1'b0;
                end else begin
                    s1_q <= pin_raw[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        lvl_q <= s3_q;
                    end
                end
            end
            assign pin_q[gi] = lvl_q;
        end
    endgenerate

    wire en_lvl = pin_q[0];
    wire pwm_lvl = pin_q[1];
    wire uvlo_lvl = pin_q[2];
    logic en_prev_q;
    wire en_rise = en_lvl & ~en_prev_q;
    wire en_fall = ~en_lvl & en_prev_q;

    // state and counters
    owd_state_t state_q, state_d;
    logic [CNT_W-1:0] timer_q, timer_d;
    logic [CNT_W-1:0] en_low_q;
    logic [CNT_W-1:0] pwm_low_q;
    logic [CNT_W-1:0] ph_cnt_q;
    logic [CNT_W-1:0] lo_len_q;
    logic [CNT_W-1:0] ack_cnt_q;
    logic armed_q;
    logic det_q;
    logic digital_q;
    logic in_frame_q, in_frame_d;
    logic [BITCNT_W-1:0] bit_cnt_q, bit_cnt_d;
    logic [FRAME_W-1:0] shift_q, shift_d;
    logic [CODE_W-1:0] code_q;
    logic ack_pend_q;
    logic ack_busy_q;
    logic accept_q;
    logic frame_end;

    wire st_off = state_q[0];
    wire st_det = state_q[1];
    wire st_chd = state_q[2];
    wire st_soft = state_q[3];
    wire st_run = state_q[4];

    // shutdown: EN low too long, PWM low too long, or supply lost
    wire en_off = en_low_q > K_EN_OFF;
    wire pwm_off = pwm_low_q > K_PWM_OFF;
    wire shutdown = ~st_off & (en_off | pwm_off | ~uvlo_lvl);
    wire start_ok = en_rise & pwm_lvl & uvlo_lvl;
    wire win_end = st_det & (timer_q >= K_WIN);
    wire det_hit = st_det & armed_q & ~en_lvl & (en_low_q == K_DET);

    always_comb begin
        state_d = state_q;
        timer_d = sat_inc(timer_q);
        case (state_q)
            ST_OFF: begin
                timer_d = '0;
                if (start_ok) begin
                    state_d = ST_DET;
                end
            end
            ST_DET: begin
                if (win_end) begin
                    state_d = ST_CHD;
                end
            end
            ST_CHD: begin
                timer_d = '0;
                if (CHAN_DET_DONE_IN) begin
                    state_d = ST_SOFT;
                end
            end
            ST_SOFT: begin
                if (timer_q >= K_SOFT) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                timer_d = '0;
            end
            default: begin
                state_d = ST_OFF;
                timer_d = '0;
            end
        endcase
        if (shutdown) begin
            state_d = ST_OFF;
            timer_d = '0;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            state_q <= ST_OFF;
            timer_q <= '0;
            en_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            en_prev_q <= en_lvl;
        end
    end

    // consecutive low time on EN and PWM
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            en_low_q <= '0;
            pwm_low_q <= '0;
        end else begin
            en_low_q <= en_lvl ? '0 : sat_inc(en_low_q);
            pwm_low_q <= pwm_lvl ? '0 : sat_inc(pwm_low_q);
        end
    end

    // detection pattern: fall after the delay, low long enough in window
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            armed_q <= 1'b0;
            det_q <= 1'b0;
            digital_q <= 1'b0;
        end else if (st_off) begin
            armed_q <= 1'b0;
            det_q <= 1'b0;
            digital_q <= 1'b0;
        end else begin
            if (st_det && en_fall) begin
                armed_q <= (timer_q >= K_DLY);
            end
            if (det_hit) begin
                det_q <= 1'b1;
            end
            if (win_end) begin
                digital_q <= det_q | det_hit;
            end
        end
    end

    // one-wire bit receiver: low phase then high phase, judged by ratio
    wire rx_on = digital_q & (st_chd | st_soft | st_run) & ~ack_busy_q;
    wire [CNT_W:0] lo2 = {lo_len_q, 1'b0};
    wire [CNT_W:0] hi2 = {ph_cnt_q, 1'b0};
    wire bit_one = {1'b0, ph_cnt_q} >= lo2;
    wire bit_zero = {1'b0, lo_len_q} >= hi2;
    wire bit_ok = bit_one | bit_zero;
    wire ph_timeout = in_frame_q & (ph_cnt_q >= K_PH_MAX);
    wire [FRAME_W-1:0] shift_in = {bit_one, shift_q[FRAME_W-1:1]};
    wire addr_ok = shift_in[FRAME_W-1:ADDR_LSB] == DEV_ADDR;
    wire accept = frame_end & addr_ok;

    always_comb begin
        in_frame_d = in_frame_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        frame_end = 1'b0;
        if (!rx_on || ph_timeout) begin
            in_frame_d = 1'b0;
            bit_cnt_d = '0;
        end else if (en_fall) begin
            if (in_frame_q && bit_ok) begin
                shift_d = shift_in;
                bit_cnt_d = bit_cnt_q + 1'b1;
                if (bit_cnt_q == LAST_BIT_IDX) begin
                    frame_end = 1'b1;
                    in_frame_d = 1'b0;
                    bit_cnt_d = '0;
                end
            end else begin
                in_frame_d = 1'b1;
                bit_cnt_d = '0;
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            ph_cnt_q <= '0;
            lo_len_q <= '0;
            in_frame_q <= 1'b0;
            bit_cnt_q <= '0;
            shift_q <= '0;
        end else begin
            ph_cnt_q <= (en_rise | en_fall) ? '0 : sat_inc(ph_cnt_q);
            if (en_rise) begin
                lo_len_q <= ph_cnt_q;
            end
            in_frame_q <= in_frame_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
        end
    end

    // brightness code and acknowledge
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            code_q <= CODE_RESET;
            accept_q <= 1'b0;
            ack_pend_q <= 1'b0;
            ack_busy_q <= 1'b0;
            ack_cnt_q <= '0;
        end else if (st_off) begin
            code_q <= CODE_RESET;
            accept_q <= 1'b0;
            ack_pend_q <= 1'b0;
            ack_busy_q <= 1'b0;
            ack_cnt_q <= '0;
        end else begin
            accept_q <= accept;
            if (accept) begin
                code_q <= shift_in[CODE_MSB:0];
                ack_pend_q <= shift_in[ACK_REQ_BIT];
            end else if (ack_pend_q && en_lvl) begin
                ack_pend_q <= 1'b0;
                ack_busy_q <= 1'b1;
                ack_cnt_q <= '0;
            end else if (ack_busy_q) begin
                ack_cnt_q <= sat_inc(ack_cnt_q);
                if (ack_cnt_q >= K_ACK) begin
                    ack_busy_q <= 1'b0;
                end
            end
        end
    end

    // code drives the sinks as full scale times code over the full steps
    assign BRIGHT_CODE_OUT = code_q;
    assign EN_OUT = 1'b0;
    assign EN_OE_OUT = ack_busy_q;
    assign DEVICE_ON_OUT = ~st_off;
    assign DIGITAL_MODE_OUT = digital_q;
    assign BOOST_RUN_OUT = st_soft | st_run;
    assign ILIM_NORMAL_OUT = st_run;
    assign CMD_ACCEPT_OUT = accept_q;

    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RESETN_IN);

    sequence soft_last;
        st_soft && (timer_q == K_SOFT);
    endsequence

    AST_SOFT_LIMIT: assert property (
        st_soft |-> !ILIM_NORMAL_OUT && timer_q <= K_SOFT)
        else $error("reduced limit window exceeded");
    AST_SOFT_END: assert property (
        soft_last and !shutdown |=> ILIM_NORMAL_OUT)
        else $error("normal limit not taken after soft start");
    AST_ENABLE: assert property (
        $rose(DEVICE_ON_OUT) |-> $past(en_rise && pwm_lvl && uvlo_lvl))
        else $error("enabled without valid start condition");
    AST_DIG_SEL: assert property (
        $rose(DIGITAL_MODE_OUT) |-> $past(st_det) && st_chd)
        else $error("digital mode chosen outside window end");
    AST_PWM_SEL: assert property (
        win_end && !det_q && !det_hit |=> !DIGITAL_MODE_OUT)
        else $error("digital mode without detection");
    AST_CODE_RST: assert property (
        $past(st_off) && st_off |-> BRIGHT_CODE_OUT == CODE_RESET)
        else $error("code not at default while off");
    AST_EN_OFF: assert property (
        DEVICE_ON_OUT && en_off |=> !DEVICE_ON_OUT)
        else $error("no shutdown after long EN low");
    AST_PWM_OFF: assert property (
        DEVICE_ON_OUT && pwm_off |=> !DEVICE_ON_OUT)
        else $error("no shutdown after long PWM low");
    AST_ACK_LEN: assert property (
        EN_OE_OUT |-> ack_cnt_q <= K_ACK && EN_OUT == 1'b0)
        else $error("acknowledge held too long");
    AST_ACK_CAUSE: assert property (
        $rose(ack_pend_q) |-> $past(accept && shift_in[ACK_REQ_BIT]))
        else $error("acknowledge without accepted request");
    AST_CODE_HOLD: assert property (
        !st_off && !accept |=> $stable(BRIGHT_CODE_OUT) || $past(st_off))
        else $error("code changed without accepted command");
endmodule

// >>> bench/owd_host.sv
// host model driving the open-drain enable line with a pull-up
`timescale 1ns/100ps
module owd_host (
    input wire logic clk_in,
    input wire logic dev_pull_in,
    output logic line_out
);
    // line starts pulled low so the first release is seen as a rise
    logic host_low = 1'b1;
    // pull-up wins when nobody pulls low
    assign line_out = !(host_low || dev_pull_in);

    task automatic hold(input logic lvl, input int cyc);
        host_low = !lvl;
        repeat (cyc) @(negedge clk_in);
    endtask

    // u is the short phase; the long phase is three times u
    task automatic send_frame(input logic [23:0] f, input int u,
                              input int nbits);
        for (int i = 0; i < nbits; i++) begin
            hold(1'b0, f[i] ? u : 3 * u);
            hold(1'b1, f[i] ? 3 * u : u);
        end
        if (nbits == 24) begin
            hold(1'b0, u);
            hold(1'b1, 1);
        end else begin
            // stay idle past the phase limit so the frame is dropped
            hold(1'b1, 450);
        end
    endtask
endmodule

// >>> bench/one_wire_dimming_control_tb_top.sv
// self-checking testbench for the one-wire dimming control block
`timescale 1ns/100ps
module one_wire_dimming_control_tb_top;
    import owd_pkg::*;
    // device address, value arbitrary
    localparam logic [7:0] DEV_A = 8'hA5;
    localparam int ACK_T = 30;
    localparam int SOFT_T = 50;
    localparam int EN_OFF_T = 100;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pwm = 1'b1;
    logic uvlo_ok = 1'b1;
    logic chd_done = 1'b0;
    wire logic en_line;
    logic en_out, en_oe, dev_on, dig, boost, ilim, acc;
    logic [CODE_W-1:0] code;
    int err_total = 0;
    int samples_checked = 0;
    int acc_cnt = 0;
    int oe_cyc = 0;

    always #20 clk = ~clk;

    owd_top #(
        .DEV_ADDR(DEV_A), .DET_LOW(20), .DET_WIN(3000), .SOFT_START(SOFT_T),
        .EN_OFF(EN_OFF_T), .PWM_OFF(200), .ACK_HOLD(ACK_T), .PHASE_MAX(400)
    ) DUT (
        .CLK_SYS_IN(clk), .RESETN_IN(rst_n), .EN_IN(en_line),
        .PWM_IN(pwm), .UVLO_OK_IN(uvlo_ok), .CHAN_DET_DONE_IN(chd_done),
        .EN_OUT(en_out), .EN_OE_OUT(en_oe), .DEVICE_ON_OUT(dev_on),
        .DIGITAL_MODE_OUT(dig), .BOOST_RUN_OUT(boost),
        .ILIM_NORMAL_OUT(ilim), .BRIGHT_CODE_OUT(code),
        .CMD_ACCEPT_OUT(acc)
    );

    owd_host HOST (
        .clk_in(clk), .dev_pull_in(en_oe && !en_out), .line_out(en_line)
    );

    always @(posedge clk) begin
        if (acc === 1'b1) acc_cnt++;
        if (en_oe === 1'b1) oe_cyc++;
    end

    task automatic chk_bit(input string nm, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_code(input logic [CODE_W-1:0] e);
        samples_checked++;
        if (code !== e) begin
            err_total++;
            $display("BAD code expected %h seen %h", e, code);
        end
    endtask

    task automatic chk_cnt(input string nm, input int e, input int g);
        samples_checked++;
        if (g != e) begin
            err_total++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic t_refuse();
        pwm = 1'b0;
        HOST.hold(1'b0, 5);
        HOST.hold(1'b1, 20);
        chk_bit("device_on", 1'b0, dev_on);
        pwm = 1'b1;
        HOST.hold(1'b0, 5);
    endtask

    task automatic t_start_digital();
        HOST.hold(1'b1, 2600);
        chk_bit("device_on", 1'b1, dev_on);
        HOST.hold(1'b0, 40);
        HOST.hold(1'b1, 500);
        chk_bit("digital", 1'b1, dig);
        chk_code(9'h1FF);
        chk_bit("en_out", 1'b0, en_out);
        chk_bit("boost", 1'b0, boost);
        chd_done = 1'b1;
        repeat (10) @(negedge clk);
        chk_bit("boost", 1'b1, boost);
        chk_bit("ilim", 1'b0, ilim);
        repeat (SOFT_T) @(negedge clk);
        chk_bit("ilim", 1'b1, ilim);
    endtask

    task automatic t_frame(input logic [23:0] f, input int u, input int n,
                           input logic [CODE_W-1:0] ec, input logic ea);
        int a;
        int o;
        a = acc_cnt;
        o = oe_cyc;
        HOST.send_frame(f, u, n);
        repeat (60) @(negedge clk);
        chk_code(ec);
        chk_bit("accept", ea, acc_cnt != a);
        chk_cnt("ack_len", (ea && f[10]) ? ACK_T : 0, oe_cyc - o);
    endtask

    task automatic t_cmds();
        t_frame({DEV_A, 16'h00A3}, 4, 24, 9'h0A3, 1'b1);
        t_frame({8'h5A, 16'h0411}, 4, 24, 9'h0A3, 1'b0);
        t_frame({DEV_A, 16'h0155}, 25, 24, 9'h155, 1'b1);
        t_frame({DEV_A, 16'h0401}, 4, 24, 9'h001, 1'b1);
        t_frame({DEV_A, 16'h0000}, 4, 24, 9'h000, 1'b1);
        t_frame({DEV_A, 16'h01FF}, 4, 12, 9'h000, 1'b0);
        t_frame({DEV_A, 16'h05FE}, 4, 24, 9'h1FE, 1'b1);
    endtask

    task automatic t_shutdown();
        HOST.hold(1'b0, EN_OFF_T + 50);
        chk_bit("device_on", 1'b0, dev_on);
        chk_code(9'h1FF);
        chk_bit("digital", 1'b0, dig);
        chk_bit("boost", 1'b0, boost);
        HOST.hold(1'b1, 3200);
        chk_bit("device_on", 1'b1, dev_on);
        chk_bit("digital", 1'b0, dig);
        t_frame({DEV_A, 16'h0010}, 4, 24, 9'h1FF, 1'b0);
        pwm = 1'b0;
        repeat (250) @(negedge clk);
        chk_bit("device_on", 1'b0, dev_on);
        chk_code(9'h1FF);
        pwm = 1'b1;
        HOST.hold(1'b0, 5);
        HOST.hold(1'b1, 20);
        chk_bit("device_on", 1'b1, dev_on);
        uvlo_ok = 1'b0;
        repeat (10) @(negedge clk);
        chk_bit("device_on", 1'b0, dev_on);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        $display("BAD watchdog expected finish seen timeout");
        results();
    end

    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (5) @(negedge clk);
        t_refuse();
        t_start_digital();
        t_cmds();
        t_shutdown();
        results();
    end
endmodule
